// File: src/rail_enable_reset_supervisor.sv
// Rail enable, hold, reset release and small control registers.
// Assumes analog comparators arrive as asynchronous digital levels
// and the register master follows the one-cycle strobe protocol.
`timescale 1ns/1ns
`default_nettype none
`include "rail_supervisor_defines.svh"

// What this block does
// - Linear-rail over-temperature turns both rails off in the same step.
// - Linear voltage register accepts codes spanning 0.8 V to 3.3 V.
// - Buck register clamps codes above 0x64; external-adjust variant ignores it.
// - Voltage registers return to defaults on undervoltage or active reset.
// - Monitor routes battery when select is 0, thermistor when 1.
// - Thermistor bias on when charger idle, monitor enabled and select 1.
// - Monitor disabled ties its output to ground for offset measurement.
// - Primary-cell mode compares battery to threshold, updates status bit.
// - Battery falling below threshold raises interrupt when unmasked.
// - Comparator disabled makes the status bit read as one.
// - Four general pins with data and direction registers.
// - Reset leaves pins 0,1 inputs and pins 2,3 idle LED sinks.
// - Open-drain reset held low, released 100 ms after condition ends.
// - Fixed variants: reset while linear power-good low or rail off.
// - Sense variant: reset below threshold, release only above hysteresis.
// - Button low or adapter power-good enables both rails.
// - Hold inputs keep their rail on after button release.
// - After first power-up with battery, rising hold turns its rail on.
// - Both rails off means shutdown of switches and control.
// - Button debounced 50 ms; valid low starts both rails together.
// - Button release turns rails off unless held.
// - Miscellaneous hold bit 5 keeps both rails on.
// - Hold pin ORed with bit 7 of the rail's voltage register.
// - Open-drain interrupt low while unmasked flag set, released on read.
module rail_enable_reset_supervisor #(
	parameter logic [`TIMER_W-1:0] DEBOUNCE_CYCLES = `TIMER_W'(`DEBOUNCE_TIME_MS * `CLK_FREQ_KHZ),
	parameter logic [`TIMER_W-1:0] RELEASE_CYCLES = `TIMER_W'(`RELEASE_TIME_MS * `CLK_FREQ_KHZ)
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire rail_supervisor_pkg::pins_t pins,
	input wire rail_supervisor_pkg::reg_req_t regReq,
	output logic [`DATA_W-1:0] rdData,
	output logic buckEnable,
	output logic linearEnable,
	output logic shutdown,
	output logic rstOut,
	output logic rstOe,
	output logic irqOut,
	output logic irqOe,
	output rail_supervisor_pkg::monitor_route_t monitorRoute,
	output logic ntcBiasEnable,
	output logic [1:0] battThresholdSel,
	output logic [`VOLT_CODE_W-1:0] buckVoltCode,
	output logic [`VOLT_CODE_W-1:0] linearVoltCode,
	output logic [`GPIO_N-1:0] gpioOut,
	output logic [`GPIO_N-1:0] gpioOe,
	output logic [`GPIO_N-1:0] ledSinkEnable
);

	// =====================================================================
	// Helpers

	// Out-of-span voltage codes are clamped to the top of the span
	function automatic logic [`DATA_W-1:0] clampVolt(input logic [`DATA_W-1:0] wr);
		logic [`VOLT_CODE_W-1:0] code;
		code = wr[`VOLT_CODE_W-1:0];
		if (code > `VOLT_CODE_MAX) begin
			code = `VOLT_CODE_MAX;
		end
		return {wr[`VOLT_HOLD_BIT], code};
	endfunction

	// Register write hit for one offset
	function automatic logic wrHit(input rail_supervisor_pkg::reg_req_t r, input logic [`ADDR_W-1:0] ofs);
		return r.wrStb && (r.addr == ofs);
	endfunction

	rail_supervisor_pkg::state_t st_reg;
	rail_supervisor_pkg::state_t st_next;

	// =====================================================================
	// Next-state logic
	always_comb begin
		logic buttonOn;
		logic startRails;
		logic holdBuck;
		logic holdLinear;
		logic thermalOff;
		logic rstCond;
		logic battAbove;
		logic cmpActive;
		logic flagRead;
		logic [`DATA_W-1:0] gpioRead;
		buttonOn = 1'b0;
		startRails = 1'b0;
		holdBuck = 1'b0;
		holdLinear = 1'b0;
		thermalOff = 1'b0;
		rstCond = 1'b0;
		battAbove = 1'b0;
		cmpActive = 1'b0;
		flagRead = 1'b0;
		gpioRead = 8'h00;
		st_next = st_reg;

		// Two-flop synchroniser; only stage two feeds logic
		st_next.sync1 = pins;
		st_next.sync2 = st_reg.sync1;
		st_next.buckHoldPrev = st_reg.sync2.buckHoldIn;
		st_next.ldoHoldPrev = st_reg.sync2.ldoHoldIn;

		// Button debounce: a level must persist the whole interval
		if (st_reg.sync2.powerButtonN == st_reg.buttonStable) begin
			st_next.debounceCnt = '0;
		end else if (st_reg.debounceCnt == DEBOUNCE_CYCLES - `TIMER_W'(1)) begin
			st_next.buttonStable = st_reg.sync2.powerButtonN;
			st_next.debounceCnt = '0;
		end else begin
			st_next.debounceCnt = st_reg.debounceCnt + `TIMER_W'(1);
		end

		// Rail enables
		buttonOn = !st_reg.buttonStable;
		startRails = buttonOn || st_reg.sync2.inputPowerGood;
		holdBuck = st_reg.sync2.buckHoldIn || st_reg.buckVolt[`VOLT_HOLD_BIT]
			|| st_reg.miscCtrl[`MISC_HOLD_BIT];
		holdLinear = st_reg.sync2.ldoHoldIn || st_reg.linearVolt[`VOLT_HOLD_BIT]
			|| st_reg.miscCtrl[`MISC_HOLD_BIT];
		// Sensor only counts while the linear rail is on
		thermalOff = st_reg.linearOn && st_reg.sync2.thermalTrip;
		if (thermalOff || st_reg.sync2.systemUvlo) begin
			st_next.buckOn = 1'b0;
			st_next.linearOn = 1'b0;
		end else begin
			// Release drops rails unless a hold source keeps them
			st_next.buckOn = startRails || (st_reg.buckOn && holdBuck)
				|| (st_reg.armed && st_reg.sync2.buckHoldIn && !st_reg.buckHoldPrev);
			st_next.linearOn = startRails || (st_reg.linearOn && holdLinear)
				|| (st_reg.armed && st_reg.sync2.ldoHoldIn && !st_reg.ldoHoldPrev);
		end
		// Hold pins may start rails only after a real first power-up
		if (!st_reg.sync2.batteryPresent) begin
			st_next.armed = 1'b0;
		end else if (startRails) begin
			st_next.armed = 1'b1;
		end
		st_next.shutdown = !st_next.buckOn && !st_next.linearOn;

		// Reset condition and release delay
		if (st_reg.sync2.senseBelow) begin
			st_next.senseCond = 1'b1;
		end else if (st_reg.sync2.senseAboveHyst) begin
			st_next.senseCond = 1'b0;
		end
		if (st_reg.sync2.useSenseInput) begin
			rstCond = st_reg.senseCond;
		end else begin
			rstCond = !st_reg.sync2.linearPowerGood || !st_reg.linearOn;
		end
		if (rstCond) begin
			st_next.rstDrive = 1'b1;
			st_next.releaseCnt = '0;
		end else if (st_reg.rstDrive) begin
			if (st_reg.releaseCnt == RELEASE_CYCLES - `TIMER_W'(1)) begin
				st_next.rstDrive = 1'b0;
				st_next.releaseCnt = '0;
			end else begin
				st_next.releaseCnt = st_reg.releaseCnt + `TIMER_W'(1);
			end
		end

		// Battery comparator, primary-cell mode only
		cmpActive = !st_reg.chgCfg2[`CFG2_CHARGE_EN_BIT] && st_reg.chgCfg2[`CFG2_CMP_EN_BIT];
		if (cmpActive) begin
			battAbove = !st_reg.sync2.battBelowThr;
		end else begin
			battAbove = 1'b1;
		end
		st_next.chgCfg3[`CFG3_ABOVE_BIT] = battAbove;
		st_next.battAbovePrev = battAbove;

		// Register reads: data lands one cycle after the strobe
		for (int i = 0; i < `GPIO_N; i++) begin
			gpioRead[i] = st_reg.gpio_direction_reg[i] ? st_reg.gpioData[i] : st_reg.sync2.gpioIn[i];
		end
		st_next.rdData = 8'h00;
		if (regReq.rdStb) begin
			if (regReq.addr == `OFS_CHG_CFG2) begin
				st_next.rdData = st_reg.chgCfg2;
			end else if (regReq.addr == `OFS_CHG_CFG3) begin
				st_next.rdData = st_reg.chgCfg3;
			end else if (regReq.addr == `OFS_BUCK_VOLT) begin
				st_next.rdData = st_reg.buckVolt;
			end else if (regReq.addr == `OFS_LINEAR_VOLT) begin
				st_next.rdData = st_reg.linearVolt;
			end else if (regReq.addr == `OFS_MISC_CTRL) begin
				st_next.rdData = st_reg.miscCtrl;
			end else if (regReq.addr == `OFS_GPIO_DATA) begin
				st_next.rdData = gpioRead;
			end else if (regReq.addr == `OFS_GPIO_DIR) begin
				st_next.rdData = st_reg.gpio_direction_reg;
			end else if (regReq.addr == `OFS_IRQ_MASK0) begin
				st_next.rdData = st_reg.irqMask0;
			end else if (regReq.addr == `OFS_IRQ_FLAG0) begin
				st_next.rdData = st_reg.irqFlag0;
				flagRead = 1'b1;
			end
		end

		// Register writes
		if (wrHit(regReq, `OFS_CHG_CFG2)) begin
			st_next.chgCfg2 = regReq.wrData;
		end
		if (wrHit(regReq, `OFS_CHG_CFG3)) begin
			st_next.chgCfg3 = {regReq.wrData[7:3], battAbove, regReq.wrData[1:0]};
		end
		if (wrHit(regReq, `OFS_BUCK_VOLT)) begin
			st_next.buckVolt = clampVolt(regReq.wrData);
		end
		if (wrHit(regReq, `OFS_LINEAR_VOLT)) begin
			st_next.linearVolt = clampVolt(regReq.wrData);
		end
		if (wrHit(regReq, `OFS_MISC_CTRL)) begin
			st_next.miscCtrl = regReq.wrData;
		end
		if (wrHit(regReq, `OFS_GPIO_DATA)) begin
			st_next.gpioData = regReq.wrData;
		end
		if (wrHit(regReq, `OFS_GPIO_DIR)) begin
			st_next.gpio_direction_reg = regReq.wrData;
		end
		if (wrHit(regReq, `OFS_IRQ_MASK0)) begin
			st_next.irqMask0 = regReq.wrData;
		end

		// Interrupt flag: reading clears, a new event in that cycle wins
		if (flagRead) begin
			st_next.irqFlag0 = 8'h00;
		end
		if (st_reg.battAbovePrev && !battAbove && !st_reg.irqMask0[`IRQ_BATT_LOW_BIT]) begin
			st_next.irqFlag0[`IRQ_BATT_LOW_BIT] = 1'b1;
		end
		st_next.irqDrive = |st_next.irqFlag0;

		// Voltage settings fall back while reset is driven or system is low
		if (st_reg.sync2.systemUvlo || st_reg.rstDrive) begin
			st_next.buckVolt = `BUCK_VOLT_RST;
			st_next.linearVolt = `LINEAR_VOLT_RST;
		end

		// Analog monitor control
		if (!st_next.miscCtrl[`MISC_MON_EN_BIT]) begin
			st_next.route = rail_supervisor_pkg::ROUTE_GROUND;
		end else if (st_next.miscCtrl[`MISC_MON_SEL_BIT]) begin
			st_next.route = rail_supervisor_pkg::ROUTE_NTC;
		end else begin
			st_next.route = rail_supervisor_pkg::ROUTE_BATTERY;
		end
		st_next.ntcBias = !st_reg.sync2.chargerActive && st_next.miscCtrl[`MISC_MON_EN_BIT]
			&& st_next.miscCtrl[`MISC_MON_SEL_BIT];

		// General pins: LED mode sinks current, else open-drive per data
		for (int i = 0; i < `GPIO_N; i++) begin
			st_next.ledSink[i] = st_next.gpio_direction_reg[i] && st_next.gpio_direction_reg[i+`GPIO_N] && st_next.gpioData[i];
			st_next.gpioOe[i] = st_next.gpio_direction_reg[i] && !st_next.gpio_direction_reg[i+`GPIO_N];
			st_next.gpioOut[i] = st_next.gpioData[i];
		end

		// Effective codes; external-adjust buck never follows the register
		st_next.buckCode = st_reg.sync2.buckExtAdjust ? `VOLT_CODE_W'(`BUCK_VOLT_RST)
			: st_next.buckVolt[`VOLT_CODE_W-1:0];
		st_next.linearCode = st_next.linearVolt[`VOLT_CODE_W-1:0];
	end

	// =====================================================================
	// State register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.buttonStable <= 1'b1;
			st_reg.shutdown <= 1'b1;
			st_reg.rstDrive <= 1'b1;
			st_reg.buckVolt <= `BUCK_VOLT_RST;
			st_reg.linearVolt <= `LINEAR_VOLT_RST;
			st_reg.miscCtrl <= `MISC_CTRL_RST;
			st_reg.chgCfg2 <= `CHG_CFG2_RST;
			st_reg.chgCfg3 <= `CHG_CFG3_RST;
			st_reg.gpioData <= `GPIO_DATA_RST;
			st_reg.gpio_direction_reg <= `GPIO_DIR_RST;
			st_reg.irqMask0 <= `IRQ_MASK0_RST;
			st_reg.battAbovePrev <= 1'b1;
			st_reg.buckCode <= `VOLT_CODE_W'(`BUCK_VOLT_RST);
			st_reg.linearCode <= `VOLT_CODE_W'(`LINEAR_VOLT_RST);
		end else begin
			st_reg <= st_next;
		end
	end

	// =====================================================================
	// Outputs straight from state flops, rstOut and irqOut tied low; open-drain lines drive low
	assign rdData = st_reg.rdData;
	assign buckEnable = st_reg.buckOn;
	assign linearEnable = st_reg.linearOn;
	assign shutdown = st_reg.shutdown;
	assign rstOut = 1'b0;
	assign rstOe = st_reg.rstDrive;
	assign irqOut = 1'b0;
	assign irqOe = st_reg.irqDrive;
	assign monitorRoute = st_reg.route;
	assign ntcBiasEnable = st_reg.ntcBias;
	assign battThresholdSel = st_reg.chgCfg3[1:0];
	assign buckVoltCode = st_reg.buckCode;
	assign linearVoltCode = st_reg.linearCode;
	assign gpioOut = st_reg.gpioOut;
	assign gpioOe = st_reg.gpioOe;
	assign ledSinkEnable = st_reg.ledSink;

endmodule
`default_nettype wire

// File: common/rail_supervisor_defines.svh
// Named constants for the rail enable and reset supervisor.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RAIL_SUPERVISOR_DEFINES_SVH
`define RAIL_SUPERVISOR_DEFINES_SVH

// =====================================================================
// Clock and timing
`define CLK_FREQ_KHZ 250000
`define DEBOUNCE_TIME_MS 50
`define RELEASE_TIME_MS 100
`define TIMER_W 25

// =====================================================================
// Register offsets (8-bit data, plain port)
`define ADDR_W 8
`define DATA_W 8
`define OFS_CHG_CFG2 8'h04
`define OFS_CHG_CFG3 8'h05
`define OFS_BUCK_VOLT 8'h07
`define OFS_LINEAR_VOLT 8'h08
`define OFS_MISC_CTRL 8'h0A
`define OFS_GPIO_DATA 8'h0B
`define OFS_GPIO_DIR 8'h0C
`define OFS_IRQ_MASK0 8'h0D
`define OFS_IRQ_FLAG0 8'h0E

// =====================================================================
// Field positions
`define VOLT_HOLD_BIT 7
`define VOLT_CODE_W 7
`define VOLT_CODE_MAX 7'h64
`define MISC_MON_EN_BIT 0
`define MISC_MON_SEL_BIT 1
`define MISC_HOLD_BIT 5
`define CFG2_CHARGE_EN_BIT 0
`define CFG2_CMP_EN_BIT 1
`define CFG3_ABOVE_BIT 2
`define IRQ_BATT_LOW_BIT 0

// =====================================================================
// Reset values
`define BUCK_VOLT_RST 8'h2A
`define LINEAR_VOLT_RST 8'h2A
`define MISC_CTRL_RST 8'h00
`define CHG_CFG2_RST 8'h01
`define CHG_CFG3_RST 8'h00
`define GPIO_DATA_RST 8'h00
`define GPIO_DIR_RST 8'hCC
`define IRQ_MASK0_RST 8'hFF
`define GPIO_N 4

`endif

// File: common/rail_supervisor_pkg.sv
// Types shared by the rail enable and reset supervisor.
// Assumes the defines header is on the include path.
`include "rail_supervisor_defines.svh"

package rail_supervisor_pkg;

	// =====================================================================
	// Monitor output routing
	typedef enum logic [1:0] {
		ROUTE_GROUND = 2'b00,
		ROUTE_BATTERY = 2'b01,
		ROUTE_NTC = 2'b10
	} monitor_route_t;

	// Asynchronous inputs, synchronised as one vector
	typedef struct packed {
		logic powerButtonN;
		logic buckHoldIn;
		logic ldoHoldIn;
		logic inputPowerGood;
		logic thermalTrip;
		logic linearPowerGood;
		logic senseBelow;
		logic senseAboveHyst;
		logic battBelowThr;
		logic batteryPresent;
		logic systemUvlo;
		logic chargerActive;
		logic buckExtAdjust;
		logic useSenseInput;
		logic [`GPIO_N-1:0] gpioIn;
	} pins_t;

	// Register bus request
	typedef struct packed {
		logic wrStb;
		logic rdStb;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wrData;
	} reg_req_t;

	// Whole state of the supervisor
	typedef struct packed {
		pins_t sync1;
		pins_t sync2;
		logic buckHoldPrev;
		logic ldoHoldPrev;
		logic buttonStable;
		logic [`TIMER_W-1:0] debounceCnt;
		logic armed;
		logic buckOn;
		logic linearOn;
		logic shutdown;
		logic senseCond;
		logic [`TIMER_W-1:0] releaseCnt;
		logic rstDrive;
		logic [`DATA_W-1:0] buckVolt;
		logic [`DATA_W-1:0] linearVolt;
		logic [`DATA_W-1:0] miscCtrl;
		logic [`DATA_W-1:0] chgCfg2;
		logic [`DATA_W-1:0] chgCfg3;
		logic [`DATA_W-1:0] gpioData;
		logic [`DATA_W-1:0] gpio_direction_reg;
		logic [`DATA_W-1:0] irqMask0;
		logic [`DATA_W-1:0] irqFlag0;
		logic battAbovePrev;
		logic irqDrive;
		monitor_route_t route;
		logic ntcBias;
		logic [`GPIO_N-1:0] gpioOut;
		logic [`GPIO_N-1:0] gpioOe;
		logic [`GPIO_N-1:0] ledSink;
		logic [`VOLT_CODE_W-1:0] buckCode;
		logic [`VOLT_CODE_W-1:0] linearCode;
		logic [`DATA_W-1:0] rdData;
	} state_t;

endpackage

// File: tb/rail_supervisor_chk.sv
// Port checker for the rail enable and reset supervisor.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ns
`default_nettype none
`include "rail_supervisor_defines.svh"
module rail_supervisor_chk #(
	parameter logic [`TIMER_W-1:0] DEBOUNCE_CYCLES = 8,
	parameter logic [`TIMER_W-1:0] RELEASE_CYCLES = 16
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire rail_supervisor_pkg::pins_t pins,
	input wire rail_supervisor_pkg::reg_req_t regReq,
	input wire logic buckEnable,
	input wire logic linearEnable,
	input wire logic shutdown,
	input wire logic rstOe,
	input wire logic irqOe,
	input wire rail_supervisor_pkg::monitor_route_t monitorRoute,
	input wire logic ntcBiasEnable,
	input wire logic [`VOLT_CODE_W-1:0] buckVoltCode,
	input wire logic [`VOLT_CODE_W-1:0] linearVoltCode
);
	int lowCnt;
	int goodCnt;
	logic senseOk;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ==========
	// Run lengths of a held button and of a clean reset cause
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lowCnt <= 0;
			goodCnt <= 0;
			senseOk <= 1'b0;
		end else begin
			lowCnt <= pins.powerButtonN ? 0 : lowCnt + 1;
			// Sense variant: cause clears only above the hysteresis level
			senseOk <= pins.senseBelow ? 1'b0 : (pins.senseAboveHyst ? 1'b1 : senseOk);
			goodCnt <= (pins.useSenseInput ? senseOk : (pins.linearPowerGood && linearEnable)) ? goodCnt + 1 : 0;
		end
	end
	// Trip must stay up through both sync stages
	sequence tripSeen;
		linearEnable && pins.thermalTrip ##1 pins.thermalTrip [*3];
	endsequence
	sequence adapterSeen;
		(pins.inputPowerGood && !pins.thermalTrip && !pins.systemUvlo) [*5];
	endsequence
	// ==========
	// Assertions
	trip_cuts_rails_a: assert property (tripSeen |-> ##[0:1] (!linearEnable && !buckEnable))
		else $error("trip left a rail on");
	volt_default_a: assert property (rstOe [*3] |-> buckVoltCode == 7'(`BUCK_VOLT_RST) && linearVoltCode == 7'(`LINEAR_VOLT_RST))
		else $error("codes not default in reset");
	ntc_bias_route_a: assert property (ntcBiasEnable |-> monitorRoute == rail_supervisor_pkg::ROUTE_NTC)
		else $error("bias without thermistor route");
	good_low_reset_a: assert property ((!pins.useSenseInput && !pins.linearPowerGood) [*4] |-> rstOe)
		else $error("reset free while power bad");
	release_wait_a: assert property ($fell(rstOe) |-> goodCnt >= RELEASE_CYCLES - 1)
		else $error("reset released early");
	release_bound_a: assert property (goodCnt >= RELEASE_CYCLES + 6 |-> !rstOe)
		else $error("reset held too long");
	adapter_start_a: assert property (adapterSeen |-> buckEnable && linearEnable)
		else $error("adapter did not start rails");
	debounce_min_a: assert property ($rose(linearEnable) && !pins.inputPowerGood && !pins.ldoHoldIn
		|-> lowCnt >= DEBOUNCE_CYCLES)
		else $error("button taken before debounce");
	debounce_max_a: assert property (lowCnt >= DEBOUNCE_CYCLES + 8 && !pins.thermalTrip && !pins.systemUvlo
		|-> buckEnable && linearEnable)
		else $error("steady press left rails off");
	shutdown_both_a: assert property ($stable({buckEnable, linearEnable}) |-> shutdown == !(buckEnable || linearEnable))
		else $error("shutdown mismatch");
	irq_on_fall_a: assert property ($rose(irqOe) |-> $past(pins.battBelowThr, 3) || $past(pins.battBelowThr, 4))
		else $error("interrupt without low battery");
	irq_clear_a: assert property (irqOe && regReq.rdStb && regReq.addr == `OFS_IRQ_FLAG0 |-> ##[1:2] !irqOe)
		else $error("interrupt kept after read");
endmodule
bind rail_enable_reset_supervisor rail_supervisor_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES)) rail_supervisor_chk_inst (.mclk(mclk), .arst_n(arst_n), .pins(pins),
	.regReq(regReq), .buckEnable(buckEnable), .linearEnable(linearEnable), .shutdown(shutdown),
	.rstOe(rstOe), .irqOe(irqOe), .monitorRoute(monitorRoute), .ntcBiasEnable(ntcBiasEnable),
	.buckVoltCode(buckVoltCode), .linearVoltCode(linearVoltCode));
`default_nettype wire

// File: tb/button_model.sv
// Push-button contact on the far side of the supervisor.
// Assumes the bench asks for a new level just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module button_model (
	input wire logic mclk,
	input wire logic pressed,
	output logic buttonN = 1'b1
);
	logic last = 1'b0;
	int bounce = 0;
	// Chatter shorter than the debounce window, then settle
	always @(posedge mclk) begin
		if (pressed != last) begin
			last <= pressed;
			bounce <= 5;
		end else if (bounce > 0) begin
			bounce <= bounce - 1;
		end
		buttonN <= (bounce > 0) ? bounce[0] : !last;
	end
endmodule
`default_nettype wire

// File: tb/rail_enable_reset_supervisor_bench.sv
// Self-checking bench for the rail enable and reset supervisor.
// Assumes shortened timers and a behavioural register model.
`timescale 1ns/1ns
`default_nettype none
`include "rail_supervisor_defines.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errCount++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITF(c) for (int n = 0; !(c); n++) begin if (n > 300) begin errCount++; giveVerdict(); end cyc(1); end
module rail_enable_reset_supervisor_bench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic pressed = 1'b0;
	logic pgDrop = 1'b0;
	logic buttonN;
	rail_supervisor_pkg::pins_t pinsTb = '0;
	rail_supervisor_pkg::pins_t pins;
	rail_supervisor_pkg::reg_req_t regReq = '0;
	rail_supervisor_pkg::monitor_route_t monitorRoute;
	logic [7:0] rdData;
	logic [7:0] code;
	logic buckEnable, linearEnable, shutdown, rstOut, rstOe, irqOut, irqOe, ntcBiasEnable;
	logic [1:0] battThresholdSel;
	logic [6:0] buckVoltCode, linearVoltCode;
	logic [3:0] gpioOut, gpioOe, ledSinkEnable;
	logic [7:0] mdl [0:15];
	logic flagM;
	logic [7:0] addrs [11] = '{`OFS_CHG_CFG2, `OFS_CHG_CFG3, `OFS_BUCK_VOLT, `OFS_LINEAR_VOLT, `OFS_MISC_CTRL,
		`OFS_GPIO_DATA, `OFS_GPIO_DIR, `OFS_IRQ_MASK0, `OFS_IRQ_FLAG0, 8'h0F, 8'hFF};
	int errCount = 0;
	int samplesChecked = 0;
	// Free-running clock
	always #2 mclk = ~mclk;
	// Button from the partner; power-good follows the linear rail
	always_comb begin
		pins = pinsTb;
		pins.powerButtonN = buttonN;
		pins.linearPowerGood = linearEnable && !pgDrop;
	end
	button_model button_model_inst (.mclk(mclk), .pressed(pressed), .buttonN(buttonN));
	rail_enable_reset_supervisor #(.DEBOUNCE_CYCLES(8), .RELEASE_CYCLES(16)) rail_enable_reset_supervisor_inst (
		.mclk(mclk), .arst_n(arst_n), .pins(pins), .regReq(regReq), .rdData(rdData),
		.buckEnable(buckEnable), .linearEnable(linearEnable), .shutdown(shutdown), .rstOut(rstOut),
		.rstOe(rstOe), .irqOut(irqOut), .irqOe(irqOe), .monitorRoute(monitorRoute),
		.ntcBiasEnable(ntcBiasEnable), .battThresholdSel(battThresholdSel), .buckVoltCode(buckVoltCode),
		.linearVoltCode(linearVoltCode), .gpioOut(gpioOut), .gpioOe(gpioOe), .ledSinkEnable(ledSinkEnable));
	// ==========
	// Model and bus tasks
	function automatic logic [7:0] expRd(input logic [7:0] a);
		logic [3:0] dir;
		dir = mdl[12][3:0];
		case (a)
			`OFS_CHG_CFG3: return {5'h00, !mdl[4][1] || mdl[4][0] || !pinsTb.battBelowThr, mdl[5][1:0]};
			`OFS_GPIO_DATA: return {4'h0, (dir & mdl[11][3:0]) | (~dir & pinsTb.gpioIn)};
			`OFS_IRQ_FLAG0: return {7'h00, flagM};
			`OFS_CHG_CFG2, `OFS_BUCK_VOLT, `OFS_LINEAR_VOLT, `OFS_MISC_CTRL, `OFS_GPIO_DIR,
			`OFS_IRQ_MASK0: return mdl[a[3:0]];
			default: return 8'h00;
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
		@(posedge mclk);
		regReq.wrStb <= 1'b0;
		if (a < 8'h10) mdl[a[3:0]] = d;
	endtask
	task automatic rdChk(input logic [7:0] a);
		logic [7:0] e;
		@(posedge mclk);
		regReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 8'h00};
		@(posedge mclk);
		regReq.rdStb <= 1'b0;
		e = expRd(a);
		#1;
		`CHK(rdData, e)
		if (a == `OFS_IRQ_FLAG0) flagM = 1'b0;
	endtask
	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'h51C3));
		mdl = '{default: 8'h00};
		mdl[4] = `CHG_CFG2_RST;
		mdl[7] = `BUCK_VOLT_RST;
		mdl[8] = `LINEAR_VOLT_RST;
		mdl[12] = `GPIO_DIR_RST;
		mdl[13] = `IRQ_MASK0_RST;
		flagM = 1'b0;
		pinsTb.gpioIn <= 4'($urandom_range(15, 0));
		pinsTb.batteryPresent <= 1'b1;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		cyc(3);
		foreach (addrs[i]) rdChk(addrs[i]);
		wr(8'hF5, 8'($urandom));
		rdChk(8'hF5);
		`CHK(gpioOe, 4'h0)
		`CHK(ledSinkEnable, 4'h0)
		wr(`OFS_GPIO_DIR, 8'h27);
		code = 8'($urandom);
		wr(`OFS_GPIO_DATA, code);
		rdChk(`OFS_GPIO_DATA);
		`CHK(gpioOe, 4'h5)
		`CHK(gpioOut, code[3:0])
		`CHK(ledSinkEnable, {2'b00, code[1], 1'b0})
		`CHK(rstOut, 1'b0)
		`CHK(irqOut, 1'b0)
		$display("test registers done");
		pinsTb.inputPowerGood <= 1'b1;
		`WAITF(buckEnable && linearEnable)
		`CHK(shutdown, 1'b0)
		`WAITF(!rstOe)
		pgDrop <= 1'b1;
		cyc(6);
		`CHK(rstOe, 1'b1)
		pgDrop <= 1'b0;
		`WAITF(!rstOe)
		repeat (4) begin
			code = 8'($urandom_range(`VOLT_CODE_MAX, 0));
			wr(`OFS_LINEAR_VOLT, code);
			wr(`OFS_BUCK_VOLT, code);
			rdChk(`OFS_LINEAR_VOLT);
			rdChk(`OFS_BUCK_VOLT);
			`CHK(linearVoltCode, code[6:0])
			`CHK(buckVoltCode, code[6:0])
		end
		pinsTb.buckExtAdjust <= 1'b1;
		cyc(4);
		`CHK(buckVoltCode, 7'(`BUCK_VOLT_RST))
		rdChk(`OFS_BUCK_VOLT);
		pinsTb.buckExtAdjust <= 1'b0;
		pinsTb.systemUvlo <= 1'b1;
		cyc(6);
		`CHK(linearEnable, 1'b0)
		pinsTb.systemUvlo <= 1'b0;
		mdl[7] = `BUCK_VOLT_RST;
		mdl[8] = `LINEAR_VOLT_RST;
		`WAITF(!rstOe)
		rdChk(`OFS_LINEAR_VOLT);
		pinsTb.useSenseInput <= 1'b1;
		pinsTb.senseBelow <= 1'b1;
		cyc(6);
		`CHK(rstOe, 1'b1)
		pinsTb.senseBelow <= 1'b0;
		cyc(6);
		`CHK(rstOe, 1'b1)
		pinsTb.senseAboveHyst <= 1'b1;
		cyc(10);
		`CHK(rstOe, 1'b1)
		`WAITF(!rstOe)
		pinsTb.useSenseInput <= 1'b0;
		pinsTb.senseAboveHyst <= 1'b0;
		cyc(4);
		$display("test supply done");
		for (int m = 0; m < 8; m++) begin
			pinsTb.chargerActive <= m[2];
			wr(`OFS_MISC_CTRL, 8'(m[1:0]));
			cyc(4);
			`CHK(monitorRoute, !m[0] ? rail_supervisor_pkg::ROUTE_GROUND : m[1] ? rail_supervisor_pkg::ROUTE_NTC : rail_supervisor_pkg::ROUTE_BATTERY)
			`CHK(ntcBiasEnable, 1'(m[0] & m[1] & !m[2]))
		end
		wr(`OFS_CHG_CFG2, 8'h02);
		code = 8'($urandom_range(3, 0));
		wr(`OFS_CHG_CFG3, code);
		wr(`OFS_IRQ_MASK0, 8'hFE);
		pinsTb.battBelowThr <= 1'b1;
		cyc(6);
		flagM = 1'b1;
		`CHK(battThresholdSel, code[1:0])
		`CHK(irqOe, 1'b1)
		rdChk(`OFS_CHG_CFG3);
		rdChk(`OFS_IRQ_FLAG0);
		cyc(2);
		`CHK(irqOe, 1'b0)
		pinsTb.battBelowThr <= 1'b0;
		wr(`OFS_IRQ_MASK0, 8'hFF);
		pinsTb.battBelowThr <= 1'b1;
		cyc(6);
		`CHK(irqOe, 1'b0)
		rdChk(`OFS_IRQ_FLAG0);
		wr(`OFS_CHG_CFG2, 8'h00);
		rdChk(`OFS_CHG_CFG3);
		wr(`OFS_CHG_CFG2, 8'h03);
		rdChk(`OFS_CHG_CFG3);
		pinsTb.battBelowThr <= 1'b0;
		$display("test monitor done");
		pinsTb.inputPowerGood <= 1'b0;
		`WAITF(shutdown)
		pressed <= 1'b1;
		`WAITF(buckEnable && linearEnable)
		pinsTb.ldoHoldIn <= 1'b1;
		pressed <= 1'b0;
		`WAITF(!buckEnable)
		`CHK(linearEnable, 1'b1)
		pinsTb.ldoHoldIn <= 1'b0;
		`WAITF(shutdown)
		`CHK(linearEnable, 1'b0)
		pinsTb.buckHoldIn <= 1'b1;
		`WAITF(buckEnable)
		cyc(2);
		`CHK(linearEnable, 1'b0)
		pinsTb.buckHoldIn <= 1'b0;
		`WAITF(shutdown)
		pinsTb.batteryPresent <= 1'b0;
		cyc(4);
		pinsTb.ldoHoldIn <= 1'b1;
		cyc(10);
		`CHK(linearEnable, 1'b0)
		pinsTb.ldoHoldIn <= 1'b0;
		pinsTb.batteryPresent <= 1'b1;
		pressed <= 1'b1;
		`WAITF(buckEnable && linearEnable)
		wr(`OFS_MISC_CTRL, 8'h20);
		pressed <= 1'b0;
		cyc(30);
		`CHK({buckEnable, linearEnable}, 2'b11)
		pinsTb.thermalTrip <= 1'b1;
		cyc(6);
		`CHK({buckEnable, linearEnable}, 2'b00)
		pinsTb.thermalTrip <= 1'b0;
		wr(`OFS_MISC_CTRL, 8'h00);
		arst_n <= 1'b0;
		cyc(2);
		`CHK(rstOe, 1'b1)
		`CHK(gpioOe, 4'h0)
		arst_n <= 1'b1;
		mdl[12] = `GPIO_DIR_RST;
		rdChk(`OFS_GPIO_DIR);
		$display("test power done");
		giveVerdict();
	end
endmodule
`default_nettype wire
